// File: hdl/pmi_pkg.sv
// Constants shared by the processor end and the testbench of the interrupt service link
// Summary of operation
// (RULE1) Fast port request served before everything else
// (RULE2) Handler checks port request flag first
// (RULE3) Flag clear: read identifier, serve highest
// (RULE4) Flag set: move port data over Y bus
// (RULE5) Then issue micro-op function two equals 5
// (RULE6) Port clears fast request on transfer grant
// (RULE7) Then test pending flag: resume or serve next
// (RULE8) Port may raise slow request on BR5
// (RULE9) Slow request at end of read/write or error
// (RULE10) Port also sets a status bit for slow
// (RULE11) BR5: read port status, then vector dispatch
// (RULE12) No port status bit: serve external bus device
// (RULE13) Memory error interrupt posted by microcode only
// (RULE14) Memory error taken during return from interrupt
// (RULE15) On error summary save memory status
// (RULE16) Corrected read, reporting on: set bit 31
// (RULE17) Low half holds software interrupt summary
// (RULE18) Dispatch at return only when level below 1A
// (RULE19) Transfer grant is a single-clock pulse
package pmi_pkg;
  // Register byte offsets on the Avalon slave
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_CMD = 6'h04;
  localparam logic [5:0] REG_STATUS = 6'h08;
  localparam logic [5:0] REG_VTB = 6'h0C;
  localparam logic [5:0] REG_WDATA = 6'h10;
  localparam logic [5:0] REG_RDATA = 6'h14;
  localparam logic [5:0] REG_LS88 = 6'h18;
  localparam logic [5:0] REG_MEMSTAT = 6'h1C;
  localparam logic [5:0] REG_DISP = 6'h20;
  // Control register fields
  localparam int CTRL_REPORT_EN_BIT = 0;
  localparam int CTRL_PRIO_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Command register field
  localparam int CMD_RET_BIT = 0;
  // Local store word that carries the posted memory error bit
  localparam logic [6:0] LS_WORD_INDEX = 7'h58;
  localparam int LS_POST_BIT = 31;
  localparam int LS_SUMMARY_W = 16;
  // Memory status field that marks a corrected read error
  localparam int MS_CORRECTED_BIT = 0;
  // Priority levels
  localparam logic [4:0] PRIO_MEMERR = 5'h1A;
  localparam logic [4:0] PRIO_BR5 = 5'h15;
  // Miscellaneous micro-operation, second function field
  localparam logic [2:0] MISC_FN2_NONE = 3'h0;
  localparam logic [2:0] MISC_FN2_GRANT = 3'h5;
  // Vector offsets into the vector table
  localparam logic [15:0] VEC_OFS_PORT = 16'h00F0;
  localparam logic [15:0] VEC_OFS_MEMERR = 16'h0054;
  // Service sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_FAST  = 6'b000010,
    ST_GRANT = 6'b000100,
    ST_CHECK = 6'b001000,
    ST_IDENT = 6'b010000,
    ST_SLOW  = 6'b100000
  } pmi_state_e;
endpackage : pmi_pkg

// File: hdl/pmi_link_if.sv
// Link between the processor service logic and the port device
`timescale 1ns/10ps
interface pmi_link_if #(parameter int DW = 32);
  logic fast_req;        // Port wants a fast data move
  logic fast_dir_wr;     // High: port wants write data; low: port holds read data
  logic [DW-1:0] port_rdata;  // Read data offered by the port
  logic [DW-1:0] ybus_data;   // Write data driven by the processor
  logic ybus_wr;         // One-cycle strobe: ybus_data valid for the port
  logic transfer_grant_pulse; // One-cycle grant to the port
  logic br_slow;         // Slow request level (BR5)
  logic stat_int;        // Port status bit: slow interrupt pending
  logic stat_rd;         // One-cycle strobe: processor reads port status
  modport cpu (
    input fast_req, fast_dir_wr, port_rdata, br_slow, stat_int,
    output ybus_data, ybus_wr, transfer_grant_pulse, stat_rd
  );
  modport port (
    output fast_req, fast_dir_wr, port_rdata, br_slow, stat_int,
    input ybus_data, ybus_wr, transfer_grant_pulse, stat_rd
  );
endinterface : pmi_link_if

// File: hdl/pmi_port_end.sv
// Port device end: raises fast and slow requests and answers the processor
`timescale 1ns/10ps
module pmi_port_end #(
  parameter int DW = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  pmi_link_if.port link,
  input wire logic i_xfer_req,
  input wire logic i_xfer_wr,
  input wire logic [DW-1:0] i_rd_word,
  input wire logic i_op_done,
  output logic [DW-1:0] o_wr_word,
  output logic o_wr_valid,
  output logic o_fast_busy,
  output logic o_slow_pending
);
  logic fast_req_r;      // Fast request flag
  logic dir_wr_r;        // Direction held with the request
  logic [DW-1:0] rdata_r; // Read word held with the request
  logic slow_r;          // Slow request and status bit
  logic [DW-1:0] wr_word_r;
  logic wr_valid_r;

  // New request only when none is outstanding, so data stays stable
  wire logic take_req = i_xfer_req & ~fast_req_r;

  // Fast request: held until the grant pulse; a request in the grant cycle is not taken, since one is still outstanding
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fast_req_r <= 1'b0;
      dir_wr_r <= 1'b0;
      rdata_r <= '0;
    end else if (take_req) begin
      fast_req_r <= 1'b1;
      dir_wr_r <= i_xfer_wr;
      rdata_r <= i_rd_word;
    end else if (link.transfer_grant_pulse) begin
      fast_req_r <= 1'b0; // RULE6
    end
  end

  // Capture write data moved over the Y bus
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_word_r <= '0;
      wr_valid_r <= 1'b0;
    end else begin
      wr_valid_r <= link.ybus_wr;
      if (link.ybus_wr) begin
        wr_word_r <= link.ybus_data;
      end
    end
  end

  // Slow request at end of an operation; a status read clears it, a new end wins
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      slow_r <= 1'b0;
    end else if (i_op_done) begin
      slow_r <= 1'b1; // RULE9
    end else if (link.stat_rd) begin
      slow_r <= 1'b0;
    end
  end

  // Link drive
  assign link.fast_req = fast_req_r;
  assign link.fast_dir_wr = dir_wr_r;
  assign link.port_rdata = rdata_r;
  assign link.br_slow = slow_r;  // RULE8
  assign link.stat_int = slow_r; // RULE10

  // User side
  assign o_wr_word = wr_word_r;
  assign o_wr_valid = wr_valid_r;
  assign o_fast_busy = fast_req_r;
  assign o_slow_pending = slow_r;
endmodule : pmi_port_end

// File: hdl/pmi_cpu_end.sv
// Processor end: interrupt service sequencer with an Avalon-MM register slave
`timescale 1ns/10ps
module pmi_cpu_end #(
  parameter int DW = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  pmi_link_if.cpu link,
  input wire logic [5:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_pending_interrupt_flag,
  input wire logic [4:0] i_intr_id,
  input wire logic i_ext_br5,
  input wire logic [15:0] i_ext_vec_ofs,
  input wire logic i_memory_error_summary,
  input wire logic [31:0] i_mem_status,
  output logic o_dispatch,
  output logic [31:0] o_dispatch_addr,
  output logic o_busy
);
  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  pmi_pkg::pmi_state_e state_r, state_nxt;
  logic [31:0] ctrl_r;       // Reporting enable and current priority level
  logic [31:0] vtb_r;        // Vector table base
  logic [DW-1:0] wdata_r;    // Write data for the port
  logic [DW-1:0] rdata_r;    // Read data taken from the port
  logic [31:0] ls88_r;       // Local store word: post bit and software summary
  logic [31:0] memstat_r;    // Saved memory status
  logic ret_pend_r;          // Return from interrupt waiting to be executed
  logic wait_r;              // Avalon waitrequest
  logic [31:0] rd_r;         // Avalon read data
  logic grant_r;
  logic ybus_wr_r;
  logic [DW-1:0] ybus_data_r;
  logic stat_rd_r;
  logic disp_r;
  logic [31:0] disp_addr_r;

  // Bus decode: an access completes in the cycle waitrequest is low
  wire logic req = i_avs_read | i_avs_write;
  wire logic wr_commit = i_avs_write & ~wait_r;
  wire logic [4:0] cur_prio = ctrl_r[pmi_pkg::CTRL_PRIO_LSB +: 5];
  wire logic report_en = ctrl_r[pmi_pkg::CTRL_REPORT_EN_BIT];
  wire logic wr_ctrl = wr_commit & (i_avs_address == pmi_pkg::REG_CTRL);
  wire logic wr_cmd = wr_commit & (i_avs_address == pmi_pkg::REG_CMD);
  wire logic wr_vtb = wr_commit & (i_avs_address == pmi_pkg::REG_VTB);
  wire logic wr_wdata = wr_commit & (i_avs_address == pmi_pkg::REG_WDATA);
  wire logic wr_ls88 = wr_commit & (i_avs_address == pmi_pkg::REG_LS88);
  wire logic ret_req = wr_cmd & i_avs_byteenable[0] & i_avs_writedata[pmi_pkg::CMD_RET_BIT];
  // Top index of the software summary half of the local store word
  localparam int LS_SUM_HI = pmi_pkg::LS_SUMMARY_W - 1;
  // Software write merged by byte lane into the local store word
  wire logic [31:0] ls88_merged = be_merge(ls88_r, i_avs_writedata, i_avs_byteenable);

  // Service conditions
  wire logic other_req = i_pending_interrupt_flag | i_ext_br5 | link.br_slow;
  wire logic slow_level = link.br_slow | i_ext_br5;
  wire logic posted = ls88_r[pmi_pkg::LS_POST_BIT];
  wire logic ret_take = (state_r == pmi_pkg::ST_IDLE) & ret_pend_r & ~link.fast_req & ~other_req;
  wire logic ret_fire = ret_take & posted & (cur_prio < pmi_pkg::PRIO_MEMERR); // RULE14 RULE18
  wire logic mem_post = i_memory_error_summary & i_mem_status[pmi_pkg::MS_CORRECTED_BIT] &
                        report_en; // RULE13 RULE16
  // Identifier chooses the slow level when it names BR5 or nothing else pends
  wire logic id_slow = slow_level &
                       ((i_intr_id == pmi_pkg::PRIO_BR5) | ~i_pending_interrupt_flag);

  // Second function field of the miscellaneous micro-operation
  wire logic [2:0] misc_fn2 = (state_r == pmi_pkg::ST_GRANT) ? pmi_pkg::MISC_FN2_GRANT :
                              pmi_pkg::MISC_FN2_NONE; // RULE5
  wire logic grant_nxt = (misc_fn2 == pmi_pkg::MISC_FN2_GRANT);

  // Dispatch decision for this cycle
  logic disp_nxt;
  logic [15:0] disp_ofs;
  always_comb begin
    disp_nxt = 1'b0;
    disp_ofs = 16'h0000;
    if (ret_fire) begin
      disp_nxt = 1'b1;
      disp_ofs = pmi_pkg::VEC_OFS_MEMERR;
    end else if (state_r == pmi_pkg::ST_IDENT && !link.fast_req && !id_slow) begin
      disp_nxt = 1'b1;
      disp_ofs = {9'h000, i_intr_id, 2'b00}; // RULE3
    end else if (state_r == pmi_pkg::ST_SLOW) begin
      if (link.stat_int) begin
        disp_nxt = 1'b1;
        disp_ofs = pmi_pkg::VEC_OFS_PORT; // RULE11
      end else if (i_ext_br5) begin
        disp_nxt = 1'b1;
        disp_ofs = i_ext_vec_ofs; // RULE12
      end
    end
  end

  // Next state of the service sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pmi_pkg::ST_IDLE: begin
        if (link.fast_req) begin
          state_nxt = pmi_pkg::ST_FAST; // RULE1
        end else if (other_req) begin
          state_nxt = pmi_pkg::ST_IDENT;
        end
      end
      pmi_pkg::ST_FAST: state_nxt = pmi_pkg::ST_GRANT;
      pmi_pkg::ST_GRANT: state_nxt = pmi_pkg::ST_CHECK;
      pmi_pkg::ST_CHECK: begin
        // Fast request may still read high here; other_req (pending flag or a slow level) alone decides
        state_nxt = other_req ? pmi_pkg::ST_IDENT : pmi_pkg::ST_IDLE; // RULE7
      end
      pmi_pkg::ST_IDENT: begin
        if (link.fast_req) begin
          state_nxt = pmi_pkg::ST_FAST; // RULE2
        end else if (id_slow) begin
          state_nxt = pmi_pkg::ST_SLOW;
        end else begin
          state_nxt = pmi_pkg::ST_IDLE;
        end
      end
      pmi_pkg::ST_SLOW: state_nxt = pmi_pkg::ST_IDLE;
      default: state_nxt = pmi_pkg::ST_IDLE;
    endcase
  end

  // Sequencer state
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= pmi_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Fast path data move and grant pulse
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rdata_r <= '0;
      ybus_wr_r <= 1'b0;
      ybus_data_r <= '0;
      grant_r <= 1'b0;
      stat_rd_r <= 1'b0;
    end else begin
      grant_r <= grant_nxt; // RULE19
      ybus_wr_r <= (state_nxt == pmi_pkg::ST_FAST) & link.fast_dir_wr; // RULE4
      stat_rd_r <= (state_nxt == pmi_pkg::ST_SLOW); // RULE11
      if (state_nxt == pmi_pkg::ST_FAST) begin
        ybus_data_r <= wdata_r;
      end
      if (state_r == pmi_pkg::ST_FAST && !link.fast_dir_wr) begin
        rdata_r <= link.port_rdata; // RULE4
      end
    end
  end

  // Memory status capture, posted bit and software summary word
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      memstat_r <= 32'h0000_0000;
      ls88_r <= 32'h0000_0000;
    end else begin
      if (i_memory_error_summary) begin
        memstat_r <= i_mem_status; // RULE15
      end
      if (wr_ls88) begin
        ls88_r[LS_SUM_HI:0] <= ls88_merged[LS_SUM_HI:0]; // RULE17
      end
      // Posting wins over a software clear or a return that consumes it
      if (mem_post) begin
        ls88_r[pmi_pkg::LS_POST_BIT] <= 1'b1; // RULE16
      end else if (ret_fire) begin
        ls88_r[pmi_pkg::LS_POST_BIT] <= 1'b0;
      end else if (wr_ls88 && i_avs_byteenable[3]) begin
        ls88_r[pmi_pkg::LS_POST_BIT] <= i_avs_writedata[pmi_pkg::LS_POST_BIT];
      end
    end
  end

  // Software registers and the pending return request
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl_r <= pmi_pkg::CTRL_RESET;
      vtb_r <= 32'h0000_0000;
      wdata_r <= '0;
      ret_pend_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= be_merge(ctrl_r, i_avs_writedata, i_avs_byteenable);
      end
      if (wr_vtb) begin
        vtb_r <= be_merge(vtb_r, i_avs_writedata, i_avs_byteenable);
      end
      if (wr_wdata) begin
        wdata_r <= be_merge(wdata_r, i_avs_writedata, i_avs_byteenable);
      end
      if (ret_req) begin
        ret_pend_r <= 1'b1;
      end else if (ret_take) begin
        ret_pend_r <= 1'b0;
      end
    end
  end

  // Dispatch pulse and target: vector table base plus offset
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      disp_r <= 1'b0;
      disp_addr_r <= 32'h0000_0000;
    end else begin
      disp_r <= disp_nxt;
      if (disp_nxt) begin
        disp_addr_r <= vtb_r + {16'h0000, disp_ofs};
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  logic [31:0] rd_mux;
  always_comb begin
    unique case (i_avs_address)
      pmi_pkg::REG_CTRL: rd_mux = ctrl_r;
      pmi_pkg::REG_STATUS: rd_mux = {24'h000000, ret_pend_r, posted, state_r};
      pmi_pkg::REG_VTB: rd_mux = vtb_r;
      pmi_pkg::REG_WDATA: rd_mux = wdata_r;
      pmi_pkg::REG_RDATA: rd_mux = rdata_r;
      pmi_pkg::REG_LS88: rd_mux = ls88_r;
      pmi_pkg::REG_MEMSTAT: rd_mux = memstat_r;
      pmi_pkg::REG_DISP: rd_mux = disp_addr_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Avalon handshake: one wait cycle, then a single cycle with waitrequest low
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wait_r <= 1'b1;
      rd_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(req & wait_r);
      if (i_avs_read && wait_r) begin
        rd_r <= rd_mux;
      end
    end
  end

  // Outputs
  assign link.ybus_data = ybus_data_r;
  assign link.ybus_wr = ybus_wr_r;
  assign link.transfer_grant_pulse = grant_r; // RULE5
  assign link.stat_rd = stat_rd_r;
  assign o_avs_readdata = rd_r;
  assign o_avs_waitrequest = wait_r;
  assign o_dispatch = disp_r;
  assign o_dispatch_addr = disp_addr_r;
  assign o_busy = ret_pend_r;
endmodule : pmi_cpu_end

// File: test/pmi_checker.sv
// Link checker between the processor end and the port end
`timescale 1ns/10ps
module pmi_checker #(
  parameter int DW = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic fast_req,
  input wire logic fast_dir_wr,
  input wire logic ybus_wr,
  input wire logic transfer_grant_pulse,
  input wire logic br_slow,
  input wire logic stat_int,
  input wire logic stat_rd
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Grant must not repeat, or the port would clear twice
  property p_grant_one;
    transfer_grant_pulse |=> !transfer_grant_pulse;
  endproperty
  a_grant_one: assert property (p_grant_one) else $error("grant too long");
  // Port drops its fast request right after the grant
  property p_grant_clr;
    transfer_grant_pulse |=> !fast_req;
  endproperty
  a_grant_clr: assert property (p_grant_clr) else $error("fast request kept");
  // Grant only follows a data move on a standing request
  property p_grant_req;
    transfer_grant_pulse |-> fast_req && $past(fast_req, 2);
  endproperty
  a_grant_req: assert property (p_grant_req) else $error("grant without move");
  // Fast requests are finished quickly, granted within 8 cycles of rising
  property p_fast_svc;
    $rose(fast_req) |-> ##[1:8] transfer_grant_pulse;
  endproperty
  a_fast_svc: assert property (p_fast_svc) else $error("fast not served");
  // Write data goes out only when the port asked for it
  property p_ywr;
    ybus_wr |-> fast_req && fast_dir_wr;
  endproperty
  a_ywr: assert property (p_ywr) else $error("stray write strobe");
  // Port status is read only after the fast flag was seen clear
  property p_fast_first;
    stat_rd |-> !$past(fast_req);
  endproperty
  a_fast_first: assert property (p_fast_first) else $error("status before fast");
  // Slow request line and status bit move together
  property p_stat_mirror;
    br_slow == stat_int;
  endproperty
  a_stat_mirror: assert property (p_stat_mirror) else $error("status bit differs");
  // A slow request gets its status read in bounded time
  property p_slow_svc;
    $rose(br_slow) |-> ##[1:10] stat_rd;
  endproperty
  a_slow_svc: assert property (p_slow_svc) else $error("slow not served");
  // Reading an interrupting port's status retires the request
  property p_slow_clr;
    stat_rd && stat_int |=> !br_slow;
  endproperty
  a_slow_clr: assert property (p_slow_clr) else $error("slow request kept");
endmodule : pmi_checker

// File: test/tb_port_and_memerr_interrupt_service.sv
// Testbench joining the processor end and the port end
`timescale 1ns/10ps
module tb_port_and_memerr_interrupt_service;
  localparam logic [31:0] VTB = 32'h0001_0000; // Vector table base used
  logic clk, rst; // Clock and reset
  logic [5:0] av_a; // Avalon address
  logic av_rd, av_wr, av_wait; // Avalon controls
  logic [31:0] av_wd, rdata, q; // Avalon data and last read
  logic pend, ext, esum, disp, busy; // Processor side levels
  logic [4:0] id; // Identifier of other source
  logic [15:0] ext_ofs; // External vector offset
  logic [31:0] mstat, daddr, last_disp, wword, last_ww, rdw;
  logic xreq, xwr, done, wvalid, fbusy, spend; // Port user side
  int error_cnt, n_checks, gnt_cnt, disp_cnt, cyc, d0, g0;
  pmi_link_if #(.DW(32)) pmi_link_if_inst ();
  pmi_cpu_end #(.DW(32)) pmi_cpu_end_inst (.i_clk_sys(clk), .i_rst(rst),
    .link(pmi_link_if_inst), .i_avs_address(av_a), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wd), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(av_wait),
    .i_pending_interrupt_flag(pend), .i_intr_id(id), .i_ext_br5(ext),
    .i_ext_vec_ofs(ext_ofs), .i_memory_error_summary(esum), .i_mem_status(mstat),
    .o_dispatch(disp), .o_dispatch_addr(daddr), .o_busy(busy));
  pmi_port_end #(.DW(32)) pmi_port_end_inst (.i_clk_sys(clk), .i_rst(rst),
    .link(pmi_link_if_inst), .i_xfer_req(xreq), .i_xfer_wr(xwr), .i_rd_word(rdw),
    .i_op_done(done), .o_wr_word(wword), .o_wr_valid(wvalid),
    .o_fast_busy(fbusy), .o_slow_pending(spend));
  pmi_checker #(.DW(32)) pmi_checker_inst (.i_clk_sys(clk), .i_rst(rst),
    .fast_req(pmi_link_if_inst.fast_req), .fast_dir_wr(pmi_link_if_inst.fast_dir_wr),
    .ybus_wr(pmi_link_if_inst.ybus_wr), .br_slow(pmi_link_if_inst.br_slow),
    .transfer_grant_pulse(pmi_link_if_inst.transfer_grant_pulse),
    .stat_int(pmi_link_if_inst.stat_int), .stat_rd(pmi_link_if_inst.stat_rd));
  // Clock source
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Event monitors update late so the main flow never races them
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (disp === 1'b1) begin
      disp_cnt <= disp_cnt + 1;
      last_disp <= daddr;
    end
    if (pmi_link_if_inst.transfer_grant_pulse === 1'b1) begin
      gnt_cnt <= gnt_cnt + 1;
    end
    if (wvalid === 1'b1) begin
      last_ww <= wword;
    end
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  // Compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low
  task av(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    av_a <= a;
    av_wr <= wr;
    av_rd <= !wr;
    av_wd <= d;
    do @(posedge clk); while (av_wait !== 1'b0);
    q = rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : av
  // Read and compare
  task rd(input logic [5:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  // Wait, bounded, for a new dispatch
  task wait_disp;
    int k;
    k = 0;
    do @(posedge clk); while (disp_cnt == d0 && k++ < 40);
  endtask : wait_disp
  // Fast transfer from the port side; pending flag driven to p once it is up
  task fast(input logic wr, input logic [31:0] w, input logic p);
    int k;
    k = 0;
    @(posedge clk);
    xreq <= 1'b1;
    xwr <= wr;
    rdw <= w;
    @(posedge clk);
    xreq <= 1'b0;
    pend <= p;
    do @(posedge clk); while (fbusy !== 1'b0 && k++ < 40);
  endtask : fast
  // Memory error report of one cycle
  task err(input logic [31:0] s);
    @(posedge clk);
    esum <= 1'b1;
    mstat <= s;
    @(posedge clk);
    esum <= 1'b0;
  endtask : err
  // Closing report
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    {av_rd, av_wr, pend, ext, esum, xreq, xwr, done} = 8'h00;
    {av_a, id, ext_ofs} = 27'h0;
    {av_wd, mstat, rdw} = 96'h0;
    {error_cnt, n_checks, gnt_cnt, disp_cnt, cyc} = '0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk({31'h0, av_wait}, 32'h1);
    rd(pmi_pkg::REG_STATUS, 32'h1);
    rd(pmi_pkg::REG_CTRL, pmi_pkg::CTRL_RESET);
    rd(6'h3C, 32'h0);
    av(1'b1, pmi_pkg::REG_VTB, VTB);
    rd(pmi_pkg::REG_VTB, VTB);
    // Port wants write data
    av(1'b1, pmi_pkg::REG_WDATA, 32'h1234_5678);
    g0 = gnt_cnt;
    fast(1'b1, 32'h0, 1'b0);
    chk(last_ww, 32'h1234_5678);
    chk(32'(gnt_cnt - g0), 32'h1);
    chk({31'h0, fbusy}, 32'h0);
    // Port holds read data, other source pending behind it
    d0 = disp_cnt;
    id <= 5'h10;
    fast(1'b0, 32'hCAFE_F00D, 1'b1);
    wait_disp();
    pend <= 1'b0;
    chk(last_disp, VTB + 32'h40);
    rd(pmi_pkg::REG_RDATA, 32'hCAFE_F00D);
    // Other source alone
    d0 = disp_cnt;
    id <= 5'h12;
    pend <= 1'b1;
    wait_disp();
    pend <= 1'b0;
    chk(last_disp, VTB + 32'h48);
    rd(pmi_pkg::REG_STATUS, 32'h1);
    // Slow request from the port at the end of an operation
    d0 = disp_cnt;
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    wait_disp();
    chk(last_disp, VTB + {16'h0, pmi_pkg::VEC_OFS_PORT});
    chk({31'h0, spend}, 32'h0);
    // Level shared with an external bus device
    d0 = disp_cnt;
    ext_ofs <= 16'h0104;
    ext <= 1'b1;
    wait_disp();
    ext <= 1'b0;
    chk(last_disp, VTB + 32'h104);
    rd(pmi_pkg::REG_STATUS, 32'h1);
    // Memory error posting: reporting off, then on
    av(1'b1, pmi_pkg::REG_LS88, 32'h0000_ABCD);
    d0 = disp_cnt;
    err(32'h1);
    rd(pmi_pkg::REG_LS88, 32'h0000_ABCD);
    av(1'b1, pmi_pkg::REG_CTRL, 32'h1A01);
    err(32'h1);
    rd(pmi_pkg::REG_LS88, 32'h8000_ABCD);
    rd(pmi_pkg::REG_MEMSTAT, 32'h1);
    chk(32'(disp_cnt - d0), 32'h0);
    // Return at level 1A must not take it
    av(1'b1, pmi_pkg::REG_CMD, 32'h1);
    rd(pmi_pkg::REG_LS88, 32'h8000_ABCD);
    chk(32'(disp_cnt - d0), 32'h0);
    // Return just below 1A takes it
    av(1'b1, pmi_pkg::REG_CTRL, 32'h1901);
    av(1'b1, pmi_pkg::REG_CMD, 32'h1);
    wait_disp();
    chk(last_disp, VTB + {16'h0, pmi_pkg::VEC_OFS_MEMERR});
    chk({31'h0, busy}, 32'h0);
    rd(pmi_pkg::REG_LS88, 32'h0000_ABCD);
    rd(pmi_pkg::REG_CMD, 32'h0);
    wrap_up();
  end
endmodule : tb_port_and_memerr_interrupt_service
